// ### hw/tdm_stream_timing_alignment.sv
// frame timing generator with per-stream bit alignment
`default_nettype none
module tdm_stream_timing_alignment
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [5:0]  reg_addr_i,
    input  wire logic [15:0] reg_wdata_i,
    input  wire logic        reg_we_i,
    input  wire logic        reg_re_i,
    output logic      [15:0] reg_rdata_o,
    output logic             timing_frame_pulse_0_o,
    output logic             timing_frame_pulse_1_o,
    output logic             timing_frame_pulse_2_o,
    output logic             timing_frame_pulse_3_o,
    output logic             sonet_frame_pulse_o,
    output logic      [4:0]  pulse_oe_o,
    output logic             timing_clock_0_o,
    output logic             timing_clock_1_o,
    output logic             timing_clock_2_o,
    output logic             timing_clock_3_o,
    output logic             telecom_rate_clock_o,
    output logic             sonet_rate_clock_o,
    output logic      [5:0]  clock_oe_o,
    output logic             frame_start_o,
    input  wire logic [15:0] stream_in_i,
    output logic      [15:0] in_bit_o,
    output logic      [15:0] in_strobe_o,
    output logic      [15:0] in_msb_o,
    input  wire logic [15:0] tx_bit_i,
    output logic      [15:0] stream_out_o,
    output logic      [15:0] tx_take_o
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------

    // one clock period in half units
    function automatic logic [12:0] span(input logic [2:0] b);
        span = 13'h0002 << b;
    endfunction

    // pulse level; a full period wide, centred on the boundary in st framing, starting at it in gci framing
    function automatic logic pulse_lvl(input logic [12:0] p,
                                       input logic [2:0]  b,
                                       input logic        gci);
        logic [12:0] w;
        w = span(b);
        if (gci)
            pulse_lvl = p < w;
        else
            pulse_lvl = !(13'(p + (w >> 1)) < w);
    endfunction

    // bit length as a shift: 2.048 Mbps is 32 half units
    function automatic logic [2:0] bit_shift(input logic [1:0] dr);
        bit_shift = 3'(3'h5 - {1'b0, dr});
    endfunction

    function automatic logic [12:0] offset(input logic [2:0] whole,
                                           input logic [2:0] qtr,
                                           input logic [2:0] s);
        offset = 13'(({10'h000, whole} << s) + (({10'h000, qtr} << s) >> 2));
    endfunction

    // code 0 is 3/4, or 1/2 at the top rate, so that the reset value gives both defaults
    function automatic logic [2:0] sample_qtr(input logic [1:0] smp,
                                              input logic       hi);
        case ({hi, smp})
            3'h0:    sample_qtr = 3'h3;
            3'h1:    sample_qtr = 3'h1;
            3'h2:    sample_qtr = 3'h2;
            3'h3:    sample_qtr = 3'h4;
            3'h7:    sample_qtr = 3'h4;
            default: sample_qtr = 3'h2;
        endcase
    endfunction

    function automatic logic [2:0] adv_qtr(input logic [1:0] fa,
                                           input logic       hi);
        if (hi)
            adv_qtr = {1'b0, fa[1], 1'b0};
        else
            adv_qtr = {1'b0, fa};
    endfunction

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [15:0] ctrl;
    logic [15:0] internal_mode_register;
    logic [15:0] ocs;
    logic [15:0] off2;
    logic [15:0] sin      [16];
    logic [15:0] sout     [16];
    logic [15:0] sin_act  [16];
    logic [15:0] sout_act [16];
    logic [15:0] rdata;

    // software writes
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl <= tdm_pkg::CR_RST;
            internal_mode_register  <= tdm_pkg::IMS_RST;
            ocs  <= tdm_pkg::OCS_RST;
            off2 <= tdm_pkg::OFF2_RST;
            for (int n = 0; n < 16; n++)
            begin
                sin[n]  <= tdm_pkg::SIN_RST;
                sout[n] <= tdm_pkg::SOUT_RST;
            end
        end
        else if (reg_we_i)
        begin
            if (reg_addr_i == tdm_pkg::ADDR_CTRL)
                ctrl <= reg_wdata_i;
            if (reg_addr_i == tdm_pkg::ADDR_MODE)
                internal_mode_register <= reg_wdata_i;
            if (reg_addr_i == tdm_pkg::ADDR_OCS)
                ocs <= reg_wdata_i;
            if (reg_addr_i == tdm_pkg::ADDR_OFF2)
                off2 <= reg_wdata_i;
            if (reg_addr_i[5:4] == tdm_pkg::SIN_PAGE)
                sin[reg_addr_i[3:0]] <= reg_wdata_i;
            if (reg_addr_i[5:4] == tdm_pkg::SOUT_PAGE)
                sout[reg_addr_i[3:0]] <= reg_wdata_i;
        end
    end

    // read data stands for the one cycle after the strobe
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !reg_re_i)
            rdata <= 16'h0000;
        else if (reg_addr_i[5:4] == tdm_pkg::SIN_PAGE)
            rdata <= sin[reg_addr_i[3:0]];
        else if (reg_addr_i[5:4] == tdm_pkg::SOUT_PAGE)
            rdata <= sout[reg_addr_i[3:0]];
        else
            case (reg_addr_i)
                tdm_pkg::ADDR_CTRL: rdata <= ctrl;
                tdm_pkg::ADDR_MODE: rdata <= internal_mode_register;
                tdm_pkg::ADDR_OCS:  rdata <= ocs;
                tdm_pkg::ADDR_OFF2: rdata <= off2;
                default:            rdata <= 16'h0000;
            endcase
    end
    assign reg_rdata_o = rdata;

    // ----------------------------------------------------------------
    // frame position
    // ----------------------------------------------------------------
    logic [31:0] acc;
    logic [31:0] next_acc;
    logic [12:0] pos;
    logic [12:0] np;
    logic        step;
    logic        boundary;

    // 8192 half units per frame; rate is exact on average only
    assign next_acc = acc + tdm_pkg::POS_INC;
    assign pos      = acc[31:19];
    assign np       = next_acc[31:19];
    assign step     = np != pos;
    assign boundary = step && (np == 13'h0000);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            acc <= 32'h0000_0000;
        else
            acc <= next_acc;
    end

    // settings move to the working copy only at the boundary
    always_ff @(posedge clk_i)
    begin
        for (int n = 0; n < 16; n++)
        begin
            if (rst_i)
            begin
                sin_act[n]  <= tdm_pkg::SIN_RST;
                sout_act[n] <= tdm_pkg::SOUT_RST;
            end
            else if (boundary)
            begin
                sin_act[n]  <= sin[n];
                sout_act[n] <= sout[n];
            end
        end
    end

    // ----------------------------------------------------------------
    // telecom and sonet oscillators, restarted every frame
    // ----------------------------------------------------------------
    logic [15:0] sacc;
    logic [15:0] tacc;
    logic        sfirst;
    logic [16:0] s_sum;
    logic [15:0] next_sacc;
    logic [15:0] next_tacc;
    logic        next_sfirst;

    assign s_sum       = {1'b0, sacc} + {1'b0, tdm_pkg::SONET_INC};
    assign next_sacc   = boundary ? 16'h0000 : s_sum[15:0];
    assign next_tacc   = boundary ? 16'h0000 : 16'(tacc + tdm_pkg::T1_INC);
    assign next_sfirst = boundary || (sfirst && !s_sum[16]);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sacc   <= 16'h0000;
            tacc   <= 16'h0000;
            sfirst <= 1'b0;
        end
        else
        begin
            sacc   <= next_sacc;
            tacc   <= next_tacc;
            sfirst <= next_sfirst;
        end
    end

    // ----------------------------------------------------------------
    // output clocks and frame pulses
    // ----------------------------------------------------------------
    logic [4:0] pulse_q;
    logic [5:0] clock_q;
    logic [2:0] c3b;
    logic       pll_ok;
    logic       div_lim;
    logic       no_pll;
    logic       div_slow;

    // a rate the input clock cannot carry is held low, not aliased
    function automatic logic rate_ok(input logic [2:0] b, input logic [15:0] cr);
        rate_ok = cr[tdm_pkg::MODE_LSB +: 2] != tdm_pkg::MODE_DIV
               || b >= 3'({1'b0, cr[tdm_pkg::CKIN_LSB +: 2]} + 3'h1);
    endfunction

    assign c3b     = 3'(tdm_pkg::CK0_BIT - {1'b0, ocs[tdm_pkg::C3_LSB +: 2]});
    assign no_pll  = ctrl[tdm_pkg::MODE_LSB +: 2] != tdm_pkg::MODE_MST
                  && !ctrl[tdm_pkg::PLL_BIT];
    assign pll_ok  = !no_pll;
    assign div_lim = ctrl[tdm_pkg::MODE_LSB +: 2] == tdm_pkg::MODE_DIV
                  && ctrl[tdm_pkg::CKIN_LSB +: 2] == 2'h2;
    // any input clock below 16.384 MHz rules out clock 2
    assign div_slow = ctrl[tdm_pkg::MODE_LSB +: 2] == tdm_pkg::MODE_DIV
                   && ctrl[tdm_pkg::CKIN_LSB +: 2] != 2'h0;

    // levels follow the next position so pins move with the step
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pulse_q       <= 5'h1F;
            clock_q       <= 6'h00;
            pulse_oe_o    <= 5'h00;
            clock_oe_o    <= 6'h00;
            frame_start_o <= 1'b0;
        end
        else
        begin
            pulse_q[0] <= pulse_lvl(np, tdm_pkg::CK0_BIT, ocs[tdm_pkg::FMT_LSB]);
            pulse_q[1] <= pulse_lvl(np, tdm_pkg::CK1_BIT, ocs[tdm_pkg::FMT_LSB + 1]);
            pulse_q[2] <= pulse_lvl(np, tdm_pkg::CK2_BIT, ocs[tdm_pkg::FMT_LSB + 2]);
            pulse_q[3] <= pulse_lvl(np, c3b, ocs[tdm_pkg::FMT_LSB + 3]);
            pulse_q[4] <= !(off2[tdm_pkg::SON_BIT] && next_sfirst);
            clock_q[0] <= rate_ok(tdm_pkg::CK0_BIT, ctrl)
                       && (np[tdm_pkg::CK0_BIT] ^ ocs[tdm_pkg::POL_LSB]);
            clock_q[1] <= rate_ok(tdm_pkg::CK1_BIT, ctrl)
                       && (np[tdm_pkg::CK1_BIT] ^ ocs[tdm_pkg::POL_LSB + 1]);
            clock_q[2] <= rate_ok(tdm_pkg::CK2_BIT, ctrl)
                       && (np[tdm_pkg::CK2_BIT] ^ ocs[tdm_pkg::POL_LSB + 2]);
            clock_q[3] <= rate_ok(c3b, ctrl)
                       && (np[c3b] ^ ocs[tdm_pkg::POL_LSB + 3]);
            clock_q[4] <= pll_ok && ((ocs[tdm_pkg::T1_BIT] ? np[tdm_pkg::E1_BIT]
                       : next_tacc[15]) ^ ocs[tdm_pkg::POL_LSB + 4]);
            clock_q[5] <= pll_ok
                       && (!next_sacc[15] ^ ocs[tdm_pkg::POL_LSB + 5]);
            pulse_oe_o    <= internal_mode_register[tdm_pkg::EN_LSB +: 5];
            clock_oe_o    <= internal_mode_register[tdm_pkg::EN_LSB + 5 +: 6];
            frame_start_o <= boundary;
        end
    end

    assign timing_frame_pulse_0_o = pulse_q[0];
    assign timing_frame_pulse_1_o = pulse_q[1];
    assign timing_frame_pulse_2_o = pulse_q[2];
    assign timing_frame_pulse_3_o = pulse_q[3];
    assign sonet_frame_pulse_o    = pulse_q[4];
    assign timing_clock_0_o       = clock_q[0];
    assign timing_clock_1_o       = clock_q[1];
    assign timing_clock_2_o       = clock_q[2];
    assign timing_clock_3_o       = clock_q[3];
    assign telecom_rate_clock_o   = clock_q[4];
    assign sonet_rate_clock_o     = clock_q[5];

    // ----------------------------------------------------------------
    // per-stream sample and launch points
    // ----------------------------------------------------------------
    logic [15:0] in_hit;
    logic [15:0] in_first;
    logic [15:0] out_hit;

    // the host keeps shifts off bidirectional lines; nothing checked here
    always_comb
    begin
        logic [2:0]  s;
        logic [2:0]  q;
        logic [12:0] m;
        logic [12:0] d;
        s        = 3'h0;
        q        = 3'h0;
        m        = 13'h0000;
        d        = 13'h0000;
        in_hit   = 16'h0000;
        in_first = 16'h0000;
        out_hit  = 16'h0000;
        for (int n = 0; n < 16; n++)
        begin
            s = bit_shift(sin_act[n][tdm_pkg::DR_LSB +: 2]);
            m = 13'((13'h0001 << s) - 13'h0001);
            q = sample_qtr(sin_act[n][tdm_pkg::SMP_LSB +: 2], s == 3'h2);
            d = offset(sin_act[n][tdm_pkg::BD_LSB +: 3], 3'h0, s);
            in_hit[n] = step && ((13'(np - offset(sin_act[n][tdm_pkg::BD_LSB +: 3], q, s))
                        & m) == 13'h0000);
            in_first[n] = 3'(13'(np - d) >> s) == {2'h0, q[2]};
            s = bit_shift(sout_act[n][tdm_pkg::DR_LSB +: 2]);
            m = 13'((13'h0001 << s) - 13'h0001);
            q = adv_qtr(sout_act[n][tdm_pkg::FA_LSB +: 2], s == 3'h2);
            d = offset(sout_act[n][tdm_pkg::AD_LSB +: 3], q, s);
            out_hit[n] = step && ((13'(np + d) & m) == 13'h0000);
        end
    end

    // sampled bits and launched bits, one strobe per bit
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            in_bit_o     <= 16'h0000;
            in_strobe_o  <= 16'h0000;
            in_msb_o     <= 16'h0000;
            stream_out_o <= 16'h0000;
            tx_take_o    <= 16'h0000;
        end
        else
        begin
            in_bit_o     <= (in_bit_o & ~in_hit) | (stream_in_i & in_hit);
            in_strobe_o  <= in_hit;
            in_msb_o     <= in_hit & in_first;
            stream_out_o <= (stream_out_o & ~out_hit) | (tx_bit_i & out_hit);
            tx_take_o    <= out_hit;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    logic [13:0] gap;
    logic        seen;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            gap  <= 14'h0000;
            seen <= 1'b0;
        end
        else
        begin
            gap  <= frame_start_o ? 14'h0001 : 14'(gap + 14'h0001);
            seen <= seen || frame_start_o;
        end
    end

    property p_frame_rate;
        seen && frame_start_o |-> gap >= 14'h30D4 && gap <= 14'h30D5;
    endproperty
    a_frame_rate: assert property (p_frame_rate)
        else $error("frame period off");

    property p_clk0_fall;
        boundary && ocs[5:0] == 6'h00 |-> clock_q[0] ##1 (!clock_q[0] && !pulse_q[0]);
    endproperty
    a_clk0_fall: assert property (p_clk0_fall)
        else $error("clock 0 not falling at boundary");

    property p_clk123;
        boundary && ocs[7:0] == 8'h00 && !div_lim && ctrl[1:0] == tdm_pkg::MODE_MST
            |-> ##1 (clock_q[3:1] == 3'h0 && pulse_q[3:1] == 3'h0);
    endproperty
    a_clk123: assert property (p_clk123)
        else $error("clocks 1-3 not low at boundary");

    property p_telecom;
        boundary && ocs[8] == 1'b0 && !ocs[tdm_pkg::FMT_LSB]
            |-> ##1 (!clock_q[4] && !pulse_q[0]);
    endproperty
    a_telecom: assert property (p_telecom)
        else $error("telecom clock not low at boundary");

    property p_sonet;
        boundary && pll_ok && !ocs[9] && off2[tdm_pkg::SON_BIT]
            |-> ##1 (clock_q[5] && !pulse_q[4]);
    endproperty
    a_sonet: assert property (p_sonet)
        else $error("sonet clock or pulse wrong at boundary");

    property p_enable;
        reg_we_i && reg_addr_i == tdm_pkg::ADDR_MODE
            ##1 !(reg_we_i && reg_addr_i == tdm_pkg::ADDR_MODE)
            |-> ##1 ({clock_oe_o, pulse_oe_o} == $past(reg_wdata_i, 2) >> 5);
    endproperty
    a_enable: assert property (p_enable)
        else $error("enables do not follow mode register");

    property p_div_limit;
        $past(div_slow) |-> !clock_q[2] && !($past(div_lim) && clock_q[1]);
    endproperty
    a_div_limit: assert property (p_div_limit)
        else $error("clock above input rate");

    property p_pll_gate;
        $past(no_pll) |-> !clock_q[4] && !clock_q[5];
    endproperty
    a_pll_gate: assert property (p_pll_gate)
        else $error("slave clocks without pll");

    property p_reset_pol;
        $fell(rst_i) |-> ocs[9:4] == 6'h00;
    endproperty
    a_reset_pol: assert property (p_reset_pol)
        else $error("polarity not negative after reset");

    property p_hold;
        !boundary |=> $stable(sin_act[0]) && $stable(sout_act[0]);
    endproperty
    a_hold: assert property (p_hold)
        else $error("stream settings changed mid frame");

    property p_launch;
        boundary && sout_act[0][8:4] == 5'h00 |-> ##1 tx_take_o[0];
    endproperty
    a_launch: assert property (p_launch)
        else $error("no launch at boundary");

    c_frame: cover property (seen && frame_start_o);
    c_msb:   cover property (in_strobe_o[0] && in_msb_o[0]);
    c_adv:   cover property (tx_take_o[0] && sout_act[0][6:4] != 3'h0);
    c_gci:   cover property (frame_start_o && ocs[0]);

endmodule
`default_nettype wire

// ### hw/tdm_pkg.sv
// constants for the tdm stream timing alignment block
`default_nettype none
package tdm_pkg;
    // rates in kHz; the frame counts half periods of 32.768 MHz
    localparam int          CLK_KHZ   = 100000;
    localparam int          HALF_KHZ  = 65536;
    localparam int          SONET_KHZ = 19440;
    localparam int          T1_KHZ    = 1544;
    localparam logic [31:0] POS_INC   = 32'((64'(HALF_KHZ) << 19) / 64'(CLK_KHZ));
    localparam logic [15:0] SONET_INC = 16'((SONET_KHZ * 65536) / CLK_KHZ);
    localparam logic [15:0] T1_INC    = 16'((T1_KHZ * 65536) / CLK_KHZ);
    // position bit that toggles at each clock rate
    localparam logic [2:0]  CK0_BIT   = 3'h3;
    localparam logic [2:0]  CK1_BIT   = 3'h2;
    localparam logic [2:0]  CK2_BIT   = 3'h1;
    localparam int          E1_BIT    = 4;
    // register addresses
    localparam logic [5:0]  ADDR_CTRL = 6'h00;
    localparam logic [5:0]  ADDR_MODE = 6'h01;
    localparam logic [5:0]  ADDR_OCS  = 6'h02;
    localparam logic [5:0]  ADDR_OFF2 = 6'h03;
    localparam logic [1:0]  SIN_PAGE  = 2'h1;
    localparam logic [1:0]  SOUT_PAGE = 2'h2;
    // field positions
    localparam int          MODE_LSB  = 0;
    localparam int          CKIN_LSB  = 5;
    localparam int          PLL_BIT   = 13;
    localparam int          EN_LSB    = 5;
    localparam int          FMT_LSB   = 0;
    localparam int          POL_LSB   = 4;
    localparam int          C3_LSB    = 12;
    localparam int          T1_BIT    = 14;
    localparam int          SON_BIT   = 10;
    localparam int          DR_LSB    = 0;
    localparam int          SMP_LSB   = 4;
    localparam int          BD_LSB    = 6;
    localparam int          AD_LSB    = 4;
    localparam int          FA_LSB    = 7;
    // timing source modes
    localparam logic [1:0]  MODE_MST  = 2'h0;
    localparam logic [1:0]  MODE_DIV  = 2'h1;
    // reset values
    localparam logic [15:0] CR_RST    = 16'h0000;
    localparam logic [15:0] IMS_RST   = 16'hFFE0;
    localparam logic [15:0] OCS_RST   = 16'h0000;
    localparam logic [15:0] OFF2_RST  = 16'h0000;
    localparam logic [15:0] SIN_RST   = 16'h0000;
    localparam logic [15:0] SOUT_RST  = 16'h0000;
endpackage
`default_nettype wire

// ### sim/tdm_far_end.sv
// far-end tdm source that drives the serial input streams
`default_nettype none
module tdm_far_end
(
    input  wire logic        clk_i,
    input  wire logic        frame_start_i,
    output logic      [15:0] stream_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------
    // frame-aligned 2.048 Mbps source
    // ------------------------------------------------
    int cyc;
    int bit_idx;
    // cycles since the frame start seen on the backplane
    always @(posedge clk_i)
    begin
        cyc <= frame_start_i ? 0 : cyc + 1;
    end
    // 256 slots per frame at the slowest rate
    always_comb bit_idx = (cyc * 256) / 12500;
    // only the first bit of each channel is set, so a slipped sample shows
    assign stream_o = {16{bit_idx[2:0] == 3'h0}};
endmodule
`default_nettype wire

// ### sim/tdm_stream_timing_alignment_bench.sv
// self-checking bench for the stream timing alignment block
`default_nettype none
module tdm_stream_timing_alignment_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i, rst_i, reg_we_i, reg_re_i, frame_start_o;
    logic [5:0]  reg_addr_i, ck, ck_q, clock_oe_o;
    logic [4:0]  fp, pulse_oe_o;
    logic [15:0] reg_wdata_i, reg_rdata_o, stream_in_i, in_bit_o, in_strobe_o;
    logic [15:0] in_msb_o, tx_bit_i, stream_out_o, tx_take_o;
    int          err_count, checks, cyc, n;
    int          cnt[6], cap[6];
    tdm_stream_timing_alignment tdm_stream_timing_alignment_inst (.clk_i(clk_i),
        .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
        .timing_frame_pulse_0_o(fp[0]), .timing_frame_pulse_1_o(fp[1]),
        .timing_frame_pulse_2_o(fp[2]), .timing_frame_pulse_3_o(fp[3]),
        .sonet_frame_pulse_o(fp[4]), .pulse_oe_o(pulse_oe_o),
        .timing_clock_0_o(ck[0]), .timing_clock_1_o(ck[1]), .timing_clock_2_o(ck[2]),
        .timing_clock_3_o(ck[3]), .telecom_rate_clock_o(ck[4]),
        .sonet_rate_clock_o(ck[5]), .clock_oe_o(clock_oe_o),
        .frame_start_o(frame_start_o), .stream_in_i(stream_in_i), .in_bit_o(in_bit_o),
        .in_strobe_o(in_strobe_o), .in_msb_o(in_msb_o), .tx_bit_i(tx_bit_i),
        .stream_out_o(stream_out_o), .tx_take_o(tx_take_o));
    tdm_far_end tdm_far_end_inst (.clk_i(clk_i), .frame_start_i(frame_start_o),
        .stream_o(stream_in_i));
    // ------------------------------------------------
    // clock and per-frame edge counters
    // ------------------------------------------------
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // rising edges per clock pin, latched at each frame start
    always @(posedge clk_i)
    begin
        ck_q <= ck;
        cyc <= frame_start_o ? 0 : cyc + 1;
        for (int k = 0; k < 6; k++)
        begin
            cap[k] <= frame_start_o ? cnt[k] : cap[k];
            cnt[k] <= frame_start_o ? 0 : cnt[k] + int'(ck[k] & ~ck_q[k]);
        end
    end
    // ------------------------------------------------
    // shared tasks
    // ------------------------------------------------
    task automatic finish_test();
        $display("errors %0d checks %0d", err_count, checks);
        if (err_count == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk_rng(input int got, input int lo, input int hi);
        checks++;
        if (got < lo || got > hi)
        begin
            err_count++;
            $display("BAD %0t count %0d not in %0d..%0d", $time, got, lo, hi);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_we_i <= 1'b1;
        @(posedge clk_i);
        reg_we_i <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe, then fall to zero
    task automatic rd(input logic [5:0] a, input logic [15:0] e);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_re_i <= 1'b1;
        @(posedge clk_i);
        reg_re_i <= 1'b0;
        #1 chk(reg_rdata_o, e);
        @(posedge clk_i);
        #1 chk(reg_rdata_o, 16'h0000);
    endtask
    // bounded wait for an event; a spent bound ends the run
    task automatic wait_for(input bit msb);
        n = 0;
        do
        begin
            @(posedge clk_i);
            #1 n++;
        end
        while ((msb ? in_msb_o[0] : frame_start_o) !== 1'b1 && n < 13000);
        if (n >= 13000)
        begin
            err_count++;
            $display("BAD %0t wait ran out", $time);
            finish_test();
        end
    endtask
    // ------------------------------------------------
    // scenarios
    // ------------------------------------------------
    task automatic s_regs();
        rd(tdm_pkg::ADDR_CTRL, tdm_pkg::CR_RST);
        rd(tdm_pkg::ADDR_MODE, tdm_pkg::IMS_RST);
        rd(tdm_pkg::ADDR_OCS, tdm_pkg::OCS_RST);
        rd({tdm_pkg::SIN_PAGE, 4'h3}, tdm_pkg::SIN_RST);
        rd({tdm_pkg::SOUT_PAGE, 4'h9}, tdm_pkg::SOUT_RST);
        wr(6'h3F, 16'hFFFF);
        rd(6'h3F, 16'h0000);
    endtask
    task automatic s_boundary();
        wait_for(1'b0);
        wait_for(1'b0);
        chk_rng(n, 12500, 12501);
        chk({11'h000, fp}, 16'h0010);
        chk({10'h000, ck}, 16'h0020);
        chk({5'h00, pulse_oe_o, clock_oe_o}, 16'h07FF);
        chk(tx_take_o, 16'hFFFF);
        chk(stream_out_o, tx_bit_i);
        // counts are latched one edge after the frame start
        @(posedge clk_i);
        #1;
        foreach (cap[k])
            chk_rng(cap[k], (k == 4) ? 191 : (k == 5) ? 2428 : (512 << k % 3) - 2,
                (k == 4) ? 195 : (k == 5) ? 2432 : (512 << k % 3) + 2);
    endtask
    // settings written early in a frame must wait for the next boundary
    task automatic s_streams();
        wr({tdm_pkg::SIN_PAGE, 4'h0}, 16'h0090);
        wr({tdm_pkg::SOUT_PAGE, 4'h0}, 16'h0090);
        wr(tdm_pkg::ADDR_CTRL, 16'h2021);
        wr(tdm_pkg::ADDR_OCS, 16'h5000);
        wr(tdm_pkg::ADDR_OFF2, 16'h0400);
        wait_for(1'b1);
        chk_rng(cyc, 33, 40);
        chk({15'h0000, in_bit_o[0]}, 16'h0001);
        wait_for(1'b0);
        chk(tx_take_o, 16'hFFFF);
        chk({15'h0000, fp[4]}, 16'h0000);
        wait_for(1'b1);
        chk_rng(cyc, 106, 113);
        chk({15'h0000, in_strobe_o[0]}, 16'h0001);
        wait_for(1'b0);
        chk(tx_take_o, 16'hFFFE);
        // let the count of the first fully configured frame latch
        @(posedge clk_i);
        #1 chk_rng(cap[2], 0, 0);
        chk_rng(cap[3], 1022, 1026);
        chk_rng(cap[4], 254, 258);
        chk_rng(cap[5], 2428, 2432);
    endtask
    task automatic s_enables();
        wr(tdm_pkg::ADDR_MODE, 16'h0420);
        @(posedge clk_i);
        @(posedge clk_i);
        #1 chk({5'h00, pulse_oe_o, clock_oe_o}, 16'h0041);
        // slave without pll; pulse 0 in gci framing, pulse 1 in st framing
        wr(tdm_pkg::ADDR_CTRL, 16'h0021);
        wr(tdm_pkg::ADDR_OCS, 16'h0001);
        wait_for(1'b0);
        chk({14'h0000, ck[5:4]}, 16'h0000);
        chk({14'h0000, fp[1:0]}, 16'h0001);
        chk({15'h0000, fp[0]}, 16'h0001);
    endtask
    initial
    begin
        rst_i = 1'b1;
        reg_we_i = 1'b0;
        reg_re_i = 1'b0;
        reg_addr_i = 6'h00;
        reg_wdata_i = 16'h0000;
        tx_bit_i = 16'h5A5A;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        s_regs();
        s_boundary();
        s_streams();
        s_enables();
        finish_test();
    end
endmodule
`default_nettype wire
